//--- hdl/chain_pkg.sv
package chain_pkg;

   // Serial word framing
   localparam int         WORD_BITS      = 16;
   localparam logic [4:0] WORD_BIT_COUNT = 5'h10;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_CHAIN     = 8'h04;
   localparam logic [7:0] OFF_CFG_WORDS = 8'h08;
   localparam logic [7:0] OFF_STATUS    = 8'h0c;

   // Field positions
   localparam int CTRL_INTERLACE = 0;
   localparam int CTRL_CASCADE   = 1;
   localparam int STAT_DONE      = 0;
   localparam int STAT_CONVERT   = 1;
   localparam int STAT_STATE_LO  = 2;
   localparam int STAT_STATE_HI  = 3;
   localparam int STAT_FWD_PEND  = 4;

   // Reset values
   localparam logic [1:0]  CTRL_RST      = 2'h0;
   localparam logic [3:0]  CHAIN_LEN_RST = 4'h1;
   localparam logic [15:0] CFG_WORDS_RST = 16'h0001;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      stCfgOwn,
      stCfgFwd,
      stConvert
   } chain_state_t;

endpackage

//--- hdl/word_link_if.sv
interface word_link_if;
   logic                            bitEn;
   logic                            load;
   logic [chain_pkg::WORD_BITS-1:0] word;
   logic                            ready;
   logic                            serial_data_out;
   logic                            frame_sync_out;

   modport tx  (input bitEn, load, word, output ready, serial_data_out, frame_sync_out);
   modport ctl (output bitEn, load, word, input ready, serial_data_out, frame_sync_out);
endinterface

//--- hdl/word_shifter.sv
module word_shifter (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Word link
   word_link_if.tx  link
);

   logic [chain_pkg::WORD_BITS-1:0] shift_reg;
   logic [4:0]                      bitCnt_reg;
   logic                            sdo_reg;
   logic                            fso_reg;

   // New word may be taken alongside the last bit, so words run back to back
   assign link.ready = (bitCnt_reg <= 5'h01);
   assign link.serial_data_out   = sdo_reg;
   assign link.frame_sync_out   = fso_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_reg  <= '0;
         bitCnt_reg <= 5'h00;
         sdo_reg    <= 1'b0;
         fso_reg    <= 1'b0;
      end else begin
         fso_reg <= 1'b0;
         if (link.bitEn) begin
            if (bitCnt_reg != 5'h00) begin
               sdo_reg    <= shift_reg[chain_pkg::WORD_BITS-1];
               shift_reg  <= {shift_reg[chain_pkg::WORD_BITS-2:0], 1'b0};
               bitCnt_reg <= bitCnt_reg - 5'h01;
            end
            if (link.load && link.ready) begin
               shift_reg  <= link.word;
               bitCnt_reg <= chain_pkg::WORD_BIT_COUNT;
               fso_reg    <= 1'b1;
            end
         end
      end
   end

endmodule

//--- hdl/daisy_chain_interlacer.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module daisy_chain_interlacer #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            sys_rst,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   input  wire logic [ADDR_W-1:0]               s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   // Chain and receiver pins
   input  wire logic                            serialDataIn,
   input  wire logic                            frameSyncIn,
   output logic                                 serialDataOut,
   output logic                                 frameSyncOut,
   output logic                                 serialClockOut,
   output logic                                 configDone,
   input  wire logic                            convStart,
   input  wire logic                            clockRateSelect,
   input  wire logic                            outputEdgeSelect,
   // Filter side
   input  wire logic [chain_pkg::WORD_BITS-1:0] sampleData,
   input  wire logic                            sampleValid,
   output logic [chain_pkg::WORD_BITS-1:0]      configWord,
   output logic                                 configWordValid,
   output logic [chain_pkg::WORD_BITS-1:0]      cascadeWord,
   output logic                                 cascadeValid
);

   localparam int W = chain_pkg::WORD_BITS;

   function automatic logic [31:0] strbMerge(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = {addr[7:2], 2'b00};
      return (a == chain_pkg::OFF_CTRL) || (a == chain_pkg::OFF_CHAIN) ||
             (a == chain_pkg::OFF_CFG_WORDS) || (a == chain_pkg::OFF_STATUS);
   endfunction

   // Registers and state
   logic [1:0]                ctrl_reg;
   logic [3:0]                chainLen_reg;
   logic [15:0]               cfgWords_reg;
   chain_pkg::chain_state_t   state_reg;
   logic [15:0]               cfgCnt_reg;
   logic                      done_reg;
   logic                      phase_reg;
   logic                      sclk_reg;
   logic [W-1:0]              rxShift_reg;
   logic [4:0]                rxCnt_reg;
   logic                      armPend_reg;
   logic                      rxDone_reg;
   logic [W-1:0]              rxWord_reg;
   logic [W-1:0]              fwdWord_reg;
   logic                      fwdPend_reg;
   logic [W-1:0]              upWord_reg;
   logic [W-1:0]              ownHold_reg;
   logic                      ownPend_reg;
   logic [3:0]                slot_reg;
   logic [W-1:0]              cfgOut_reg;
   logic                      cfgOutValid_reg;
   logic [W-1:0]              casOut_reg;
   logic                      casValid_reg;

   // AXI state
   logic              awRdy_reg, wRdy_reg, awHeld_reg, wHeld_reg;
   logic              bvalid_reg, arRdy_reg, rvalid_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;
   logic [1:0]        bresp_reg, rresp_reg;
   logic [31:0]       rdata_reg;

   logic         bitEn;
   logic         converting;
   logic         txLoad;
   logic [W-1:0] ownTerm;
   logic [W-1:0] convWord;
   logic         doWrite, awHeld_next, wHeld_next, bvalid_next, arTake, rvalid_next;
   logic [31:0]  ctrlMerged, chainMerged, cfgMerged;

   word_link_if link ();

   word_shifter u_shifter (
      .clk     (clk),
      .sys_rst (sys_rst),
      .link    (link)
   );

   // Bit timing: every cycle at full rate, every other cycle at half rate
   assign bitEn      = clockRateSelect ? (phase_reg == outputEdgeSelect) : 1'b1;
   assign converting = (state_reg == chain_pkg::stConvert);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_reg <= 1'b0;
         sclk_reg  <= 1'b1;
      end else begin
         phase_reg <= ~phase_reg;
         // Full rate: the pin stands high and the board uses the master clock
         sclk_reg  <= clockRateSelect ? (bitEn ^ outputEdgeSelect) : 1'b1;
      end
   end

   // Word receiver; a frame sync seen off a bit cell waits for the next one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxShift_reg <= '0;
         rxCnt_reg   <= 5'h00;
         armPend_reg <= 1'b0;
         rxDone_reg  <= 1'b0;
         rxWord_reg  <= '0;
      end else begin
         rxDone_reg <= 1'b0;
         if (bitEn) begin
            if (rxCnt_reg != 5'h00) begin
               rxShift_reg <= {rxShift_reg[W-2:0], serialDataIn};
               rxCnt_reg   <= rxCnt_reg - 5'h01;
               if (rxCnt_reg == 5'h01) begin
                  rxDone_reg <= 1'b1;
                  rxWord_reg <= {rxShift_reg[W-2:0], serialDataIn};
               end
            end
            if (frameSyncIn || armPend_reg) begin
               rxCnt_reg <= chain_pkg::WORD_BIT_COUNT;
            end
            armPend_reg <= 1'b0;
         end else if (frameSyncIn) begin
            armPend_reg <= 1'b1;
         end
      end
   end

   // Configuration and conversion sequencing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg       <= chain_pkg::stCfgOwn;
         cfgCnt_reg      <= 16'h0000;
         done_reg        <= 1'b0;
         cfgOut_reg      <= '0;
         cfgOutValid_reg <= 1'b0;
      end else begin
         cfgOutValid_reg <= 1'b0;
         unique case (state_reg)
            chain_pkg::stCfgOwn: begin
               if (rxDone_reg) begin
                  cfgOut_reg      <= rxWord_reg;
                  cfgOutValid_reg <= 1'b1;
                  cfgCnt_reg      <= cfgCnt_reg + 16'h0001;
                  if (cfgCnt_reg + 16'h0001 >= cfgWords_reg) begin
                     state_reg <= chain_pkg::stCfgFwd;
                     done_reg  <= 1'b1;
                  end
               end
            end
            chain_pkg::stCfgFwd: begin
               if (convStart) begin
                  state_reg <= chain_pkg::stConvert;
               end
            end
            chain_pkg::stConvert: begin
               if (!convStart) begin
                  state_reg <= chain_pkg::stCfgFwd;
               end
            end
         endcase
      end
   end

   // Forwarding of configuration words after our own; set wins over clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fwdWord_reg <= '0;
         fwdPend_reg <= 1'b0;
      end else if (rxDone_reg && state_reg == chain_pkg::stCfgFwd) begin
         fwdWord_reg <= rxWord_reg;
         fwdPend_reg <= 1'b1;
      end else if (txLoad && !converting) begin
         fwdPend_reg <= 1'b0;
      end
   end

   // Interlacer: held upstream word plus zero-padded own sample
   assign ownTerm  = (ctrl_reg[chain_pkg::CTRL_INTERLACE] && slot_reg == 4'h0 && ownPend_reg) ?
                     ownHold_reg : '0;
   assign convWord = ctrl_reg[chain_pkg::CTRL_INTERLACE] ?
                     (upWord_reg + ownTerm) : ownHold_reg;
   assign txLoad   = bitEn && link.ready && (converting || fwdPend_reg);

   assign link.bitEn = bitEn;
   assign link.load  = txLoad;
   assign link.word  = converting ? convWord : fwdWord_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upWord_reg <= '0;
      end else if (rxDone_reg && converting) begin
         upWord_reg <= rxWord_reg;
      end else if (txLoad && converting) begin
         upWord_reg <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ownHold_reg <= '0;
         ownPend_reg <= 1'b0;
      end else if (sampleValid) begin
         ownHold_reg <= sampleData;
         ownPend_reg <= 1'b1;
      end else if (txLoad && converting && slot_reg == 4'h0) begin
         ownPend_reg <= 1'b0;
      end
   end

   // One own slot per chain length words, giving clock/(16 x N) per device at full rate, clock/(32 x N) at half rate
   always_ff @(posedge clk) begin
      if (sys_rst || !converting) begin
         slot_reg <= 4'h0;
      end else if (txLoad) begin
         slot_reg <= (slot_reg + 4'h1 >= chainLen_reg) ? 4'h0 : slot_reg + 4'h1;
      end
   end

   // Upstream partial result handed to the local filter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         casOut_reg   <= '0;
         casValid_reg <= 1'b0;
      end else begin
         casValid_reg <= rxDone_reg && converting && ctrl_reg[chain_pkg::CTRL_CASCADE];
         if (rxDone_reg && converting) begin
            casOut_reg <= rxWord_reg;
         end
      end
   end

   // AXI4-Lite write path
   assign doWrite     = awHeld_reg && wHeld_reg && !bvalid_reg;
   assign awHeld_next = (awHeld_reg || (s_axi_awvalid && awRdy_reg)) && !doWrite;
   assign wHeld_next  = (wHeld_reg || (s_axi_wvalid && wRdy_reg)) && !doWrite;
   assign bvalid_next = doWrite || (bvalid_reg && !s_axi_bready);
   assign ctrlMerged  = strbMerge({30'h0, ctrl_reg}, wData_reg, wStrb_reg);
   assign chainMerged = strbMerge({28'h0, chainLen_reg}, wData_reg, wStrb_reg);
   assign cfgMerged   = strbMerge({16'h0, cfgWords_reg}, wData_reg, wStrb_reg);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awRdy_reg  <= 1'b0;
         wRdy_reg   <= 1'b0;
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= chain_pkg::RESP_OKAY;
         awAddr_reg <= '0;
         wData_reg  <= 32'h0000_0000;
         wStrb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && awRdy_reg) begin
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wRdy_reg) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            bresp_reg <= isMapped(awAddr_reg) ? chain_pkg::RESP_OKAY : chain_pkg::RESP_DECERR;
         end
         awHeld_reg <= awHeld_next;
         wHeld_reg  <= wHeld_next;
         bvalid_reg <= bvalid_next;
         awRdy_reg  <= !awHeld_next && !bvalid_next;
         wRdy_reg   <= !wHeld_next && !bvalid_next;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg     <= chain_pkg::CTRL_RST;
         chainLen_reg <= chain_pkg::CHAIN_LEN_RST;
         cfgWords_reg <= chain_pkg::CFG_WORDS_RST;
      end else if (doWrite) begin
         unique case ({awAddr_reg[7:2], 2'b00})
            chain_pkg::OFF_CTRL:
               ctrl_reg <= ctrlMerged[1:0];
            chain_pkg::OFF_CHAIN:
               chainLen_reg <= chainMerged[3:0];
            chain_pkg::OFF_CFG_WORDS:
               cfgWords_reg <= cfgMerged[15:0];
            default: ;
         endcase
      end
   end

   // AXI4-Lite read path, one cycle from address to data
   assign arTake      = s_axi_arvalid && arRdy_reg;
   assign rvalid_next = arTake || (rvalid_reg && !s_axi_rready);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arRdy_reg  <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= chain_pkg::RESP_OKAY;
      end else begin
         if (arTake) begin
            rresp_reg <= isMapped(s_axi_araddr) ? chain_pkg::RESP_OKAY : chain_pkg::RESP_DECERR;
            unique case ({s_axi_araddr[7:2], 2'b00})
               chain_pkg::OFF_CTRL:      rdata_reg <= {30'h0, ctrl_reg};
               chain_pkg::OFF_CHAIN:     rdata_reg <= {28'h0, chainLen_reg};
               chain_pkg::OFF_CFG_WORDS: rdata_reg <= {16'h0, cfgWords_reg};
               chain_pkg::OFF_STATUS:    rdata_reg <= {27'h0, fwdPend_reg, state_reg,
                                                       converting, done_reg};
               default:                  rdata_reg <= 32'h0000_0000;
            endcase
         end
         rvalid_reg <= rvalid_next;
         arRdy_reg  <= !rvalid_next;
      end
   end

   // Outputs
   assign s_axi_awready   = awRdy_reg;
   assign s_axi_wready    = wRdy_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_arready   = arRdy_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign serialDataOut   = link.serial_data_out;
   assign frameSyncOut    = link.frame_sync_out;
   assign serialClockOut  = sclk_reg;
   assign configDone      = done_reg;
   assign configWord      = cfgOut_reg;
   assign configWordValid = cfgOutValid_reg;
   assign cascadeWord     = casOut_reg;
   assign cascadeValid    = casValid_reg;

endmodule

//--- verif/chain_sva.sv
module chain_sva (
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Bus answers
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       s_axi_arready,
   // Pins
   input wire logic       frameSyncOut,
   input wire logic       serialClockOut,
   input wire logic       clockRateSelect,
   input wire logic       configDone,
   input wire logic       configWordValid,
   input wire logic       cascadeValid
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Words are 16 bit cells long, so no sync within the next 8 clocks
   sequence wordGap;
      !frameSyncOut [*8];
   endsequence
   sequence halfRate;
      clockRateSelect [*3];
   endsequence

   fso_gap_a: assert property (frameSyncOut |=> wordGap)
      else $error("frame sync repeated inside a word");
   half_rate_a: assert property (halfRate |-> serialClockOut != $past(serialClockOut))
      else $error("serial clock not toggling at half rate");
   full_rate_a: assert property (!clockRateSelect [*2] |-> serialClockOut)
      else $error("serial clock not held in full rate");
   done_hold_a: assert property (configDone |=> configDone)
      else $error("config done dropped");
   done_cause_a: assert property ($rose(configDone) |-> configWordValid
                                 || $past(configWordValid))
      else $error("config done without own word");
   cfg_pulse_a: assert property (configWordValid |=> !configWordValid)
      else $error("config word valid longer than one cycle");
   cascade_pulse_a: assert property (cascadeValid |=> !cascadeValid [*8])
      else $error("cascade word valid repeated too soon");
   bresp_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   rresp_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not retired");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while answer pending");
endmodule

bind daisy_chain_interlacer chain_sva sva (.clk, .sys_rst, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_arready, .frameSyncOut, .serialClockOut,
   .clockRateSelect, .configDone, .configWordValid, .cascadeValid);

//--- verif/upstream_link_model.sv
module upstream_link_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Request
   input  wire logic        go,
   input  wire logic [15:0] word,
   // Chain pins
   output logic             frame_sync_in,
   output logic             serial_data_in,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] shiftReg;
   logic [4:0]  bitCnt;

   // Idle data toggles every clock, starting with the inverse of the last bit; it holds its value on the frame sync clock
   always_ff @(posedge clk) begin
      frame_sync_in <= 1'b0;
      if (sys_rst) begin
         busy <= 1'b0;
         serial_data_in <= 1'b0;
      end else if (go && !busy) begin
         frame_sync_in <= 1'b1;
         shiftReg <= word;
         bitCnt <= 5'h10;
         busy <= 1'b1;
      end else if (busy && bitCnt != 5'h00) begin
         serial_data_in <= shiftReg[15];
         shiftReg <= {shiftReg[14:0], 1'b0};
         bitCnt <= bitCnt - 5'h01;
      end else begin
         busy <= 1'b0;
         serial_data_in <= ~serial_data_in;
      end
   end
endmodule

//--- verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, sys_rst = 1'b1;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0, rData;
   logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
   logic awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp, rResp;
   logic convStart = 0, rateSel = 0, edgeSel = 0, sampleValid = 0, upGo = 0;
   logic [15:0] sampleData = 16'h0, upWord = 16'h0, cfgWord, casWord;
   logic serial_data_out, frame_sync_out, sclk, cfgDone, cfgValid, casValid, frame_sync_in, serial_data_in, upBusy, nextSync;
   int fail_count = 0, num_checks = 0, cycles = 0;

   daisy_chain_interlacer dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .serialDataIn(serial_data_in), .frameSyncIn(frame_sync_in),
      .serialDataOut(serial_data_out), .frameSyncOut(frame_sync_out), .serialClockOut(sclk),
      .configDone(cfgDone), .convStart(convStart), .clockRateSelect(rateSel),
      .outputEdgeSelect(edgeSel), .sampleData(sampleData), .sampleValid(sampleValid),
      .configWord(cfgWord), .configWordValid(cfgValid), .cascadeWord(casWord),
      .cascadeValid(casValid));
   upstream_link_model up (.clk(clk), .sys_rst(sys_rst), .go(upGo), .word(upWord),
      .frame_sync_in(frame_sync_in), .serial_data_in(serial_data_in), .busy(upBusy));

   always #25 clk = ~clk;
   // Whole run needs a few hundred clocks; anything past this is a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (!bValid);
      bReady <= 1'b0;
      check({30'h0, bResp}, {30'h0, er});
   endtask

   task readCheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                  input logic [1:0] er);
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge clk);
         if (arReady) arValid <= 1'b0;
      end while (!rValid);
      rReady <= 1'b0;
      check(rData & m, e);
      check({30'h0, rResp}, {30'h0, er});
   endtask

   task sendWord(input logic [15:0] w);
      @(posedge clk);
      upWord <= w;
      upGo <= 1'b1;
      @(posedge clk);
      upGo <= 1'b0;
      do @(posedge clk); while (upBusy);
   endtask

   // Next sync lands with the last bit, so it is remembered for the next call
   task recvWord(output logic [15:0] w);
      if (!nextSync) do @(posedge clk); while (!frame_sync_out);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         w = {w[14:0], serial_data_out};
      end
      nextSync = frame_sync_out;
   endtask

   task testRegs();
      readCheck(chain_pkg::OFF_CTRL, 32'h3, {30'h0, chain_pkg::CTRL_RST}, 2'h0);
      readCheck(chain_pkg::OFF_CHAIN, 32'hf, {28'h0, chain_pkg::CHAIN_LEN_RST}, 2'h0);
      readCheck(chain_pkg::OFF_CFG_WORDS, 32'hffff, {16'h0, chain_pkg::CFG_WORDS_RST}, 2'h0);
      readCheck(chain_pkg::OFF_STATUS, 32'hf, 32'h0, 2'h0);
      readCheck(8'h40, 32'hffffffff, 32'h0, chain_pkg::RESP_DECERR);
      axiWrite(8'h40, 32'h1, chain_pkg::RESP_DECERR);
      axiWrite(chain_pkg::OFF_CHAIN, 32'h3, chain_pkg::RESP_OKAY);
      readCheck(chain_pkg::OFF_CHAIN, 32'hf, 32'h3, 2'h0);
      axiWrite(chain_pkg::OFF_CHAIN, 32'h1, chain_pkg::RESP_OKAY);
   endtask

   task testConfig();
      logic [15:0] got;
      fork
         sendWord(16'ha5c3);
         repeat (60) begin
            @(posedge clk);
            if (cfgValid) begin
               got = cfgWord;
               break;
            end
         end
      join
      check({16'h0, got}, 32'ha5c3);
      check({31'h0, cfgDone}, 32'h1);
      readCheck(chain_pkg::OFF_STATUS, 32'hf, 32'h5, 2'h0);
      nextSync = 1'b0;
      fork
         sendWord(16'h3c96);
         recvWord(got);
      join
      check({16'h0, got}, 32'h3c96);
   endtask

   task testCascade();
      logic [15:0] got;
      axiWrite(chain_pkg::OFF_CTRL, 32'h2, chain_pkg::RESP_OKAY);
      convStart <= 1'b1;
      readCheck(chain_pkg::OFF_STATUS, 32'hf, 32'hb, 2'h0);
      fork
         sendWord(16'h7e01);
         repeat (60) begin
            @(posedge clk);
            if (casValid) begin
               got = casWord;
               break;
            end
         end
      join
      check({16'h0, got}, 32'h7e01);
   endtask

   task testInterlace();
      logic [15:0] got;
      logic hit;
      axiWrite(chain_pkg::OFF_CTRL, 32'h1, chain_pkg::RESP_OKAY);
      // Let one load clear the upstream word left from the cascade run
      repeat (17) @(posedge clk);
      sampleData <= 16'h1234;
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      nextSync = 1'b0;
      hit = 1'b0;
      repeat (4) begin
         recvWord(got);
         if (got === 16'h1234) hit = 1'b1;
      end
      check({31'h0, hit}, 32'h1);
      check({31'h0, nextSync}, 32'h1);
   endtask

   task testRate();
      logic prev;
      rateSel <= 1'b1;
      edgeSel <= 1'b1;
      repeat (3) @(posedge clk);
      prev = sclk;
      repeat (8) begin
         @(posedge clk);
         check({31'h0, sclk}, {31'h0, ~prev});
         prev = sclk;
      end
      do @(posedge clk); while (!frame_sync_out);
      check({31'h0, sclk}, 32'h0);
      edgeSel <= 1'b0;
      repeat (2) @(posedge clk);
      do @(posedge clk); while (!frame_sync_out);
      check({31'h0, sclk}, 32'h1);
      rateSel <= 1'b0;
      repeat (3) @(posedge clk);
      repeat (8) begin
         @(posedge clk);
         check({31'h0, sclk}, 32'h1);
      end
   endtask

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      testRegs();
      testConfig();
      testCascade();
      testInterlace();
      testRate();
      final_report();
   end
endmodule
